/* verilog/cup_defines.svh */
`ifndef CUP_DEFINES_SVH
`define CUP_DEFINES_SVH

// ----------------------------------------
// Unit mode select encodings
// ----------------------------------------
`define CUP_MODE_OFF 4'h0
`define CUP_MODE_CAP_FALL 4'h4
`define CUP_MODE_CAP_RISE 4'h5
`define CUP_MODE_CAP_RISE4 4'h6
`define CUP_MODE_CAP_RISE16 4'h7

// ----------------------------------------
// Prescaler terminal counts (edges minus one)
// ----------------------------------------
`define CUP_PS_LAST_1 4'h0
`define CUP_PS_LAST_4 4'h3
`define CUP_PS_LAST_16 4'hF

// ----------------------------------------
// Timebase timer modes
// ----------------------------------------
`define CUP_TMR_TIMER 2'h0
`define CUP_TMR_SYNC 2'h1
`define CUP_TMR_ASYNC 2'h2

// ----------------------------------------
// Instruction clock divider (Fosc/4)
// ----------------------------------------
`define CUP_INSTR_DIV 4
`define CUP_DIV_LAST 2'h3
`define CUP_TMR_ONE 16'h0001

`endif

/* verilog/cup_pkg.sv */
`include "cup_defines.svh"

package cup_pkg;

  typedef enum logic [1:0] {
    CUP_TM_TIMER = `CUP_TMR_TIMER,
    CUP_TM_SYNC = `CUP_TMR_SYNC,
    CUP_TM_ASYNC = `CUP_TMR_ASYNC
  } cup_tmr_mode_t;

  typedef struct packed {
    logic prev;
    logic [3:0] cnt;
    logic evt;
  } cup_pre_state_t;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic [1:0] div;
    logic [15:0] tmr;
    logic [15:0] hold;
    logic flag;
    logic irq;
    logic [3:0] mode_q;
    logic en_q;
  } cup_top_state_t;

  function automatic logic cup_is_capture(input logic [3:0] mode);
    return (mode == `CUP_MODE_CAP_FALL) || (mode == `CUP_MODE_CAP_RISE) ||
           (mode == `CUP_MODE_CAP_RISE4) || (mode == `CUP_MODE_CAP_RISE16);
  endfunction

  function automatic logic [3:0] cup_ps_last(input logic [3:0] mode);
    case (mode)
      `CUP_MODE_CAP_RISE4: return `CUP_PS_LAST_4;
      `CUP_MODE_CAP_RISE16: return `CUP_PS_LAST_16;
      default: return `CUP_PS_LAST_1;
    endcase
  endfunction

endpackage

/* verilog/cup_pre_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface cup_pre_if;
  logic pin_lvl;
  logic active;
  logic [3:0] mode;
  logic evt;

  modport top (output pin_lvl, output active, output mode, input evt);
  modport pre (input pin_lvl, input active, input mode, output evt);
endinterface

`default_nettype wire

/* verilog/cup_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cup_defines.svh"

module cup_prescaler
  import cup_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  cup_pre_if.pre bus
);

  cup_pre_state_t st_r;
  cup_pre_state_t st_nxt;
  logic hit;

  // ----------------------------------------
  // Edge qualify and count
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = bus.pin_lvl;
    st_nxt.evt = 1'b0;
    if (bus.mode == `CUP_MODE_CAP_FALL) begin
      hit = st_r.prev & ~bus.pin_lvl;
    end else begin
      hit = ~st_r.prev & bus.pin_lvl;
    end
    if (!bus.active) begin
      st_nxt.cnt = '0;
    end else if (hit) begin
      // Count kept across setting changes
      if (st_r.cnt >= cup_ps_last(bus.mode)) begin
        st_nxt.cnt = '0;
        st_nxt.evt = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.evt = st_r.evt;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_clear_when_idle;
    @(posedge i_clock) disable iff (!i_rst_n) !bus.active |=> st_r.cnt == '0;
  endproperty
  a_clear_when_idle: assert property (p_clear_when_idle) else $error("prescaler not cleared");

  property p_reset_clears;
    @(posedge i_clock) !i_rst_n |=> st_r.cnt == '0 && !st_r.evt;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left prescaler");

  property p_hold_without_edge;
    @(posedge i_clock) disable iff (!i_rst_n)
      bus.active && bus.pin_lvl == st_r.prev |=> st_r.cnt == $past(st_r.cnt) && !st_r.evt;
  endproperty
  a_hold_without_edge: assert property (p_hold_without_edge) else $error("count moved w/o edge");

  property p_sixteen_edges;
    @(posedge i_clock) disable iff (!i_rst_n)
      st_r.evt && $past(bus.mode) == `CUP_MODE_CAP_RISE16 |-> $past(st_r.cnt) == `CUP_PS_LAST_16;
  endproperty
  a_sixteen_edges: assert property (p_sixteen_edges) else $error("event before 16 edges");

endmodule

`default_nettype wire

/* verilog/cup_capture_unit.sv */
// Behaviour
// - Changing the capture mode may raise a spurious capture interrupt flag.
// - The edge prescaler has four settings chosen by the 4-bit mode select field.
// - The prescaler count is cleared while the unit is off or not in a capture mode.
// - Any reset clears the prescaler count.
// - Switching between prescale settings keeps the count and may raise a spurious capture.
// - The timebase counts either instruction clock ticks or external clock edges.
// - On the instruction clock the timebase stops during sleep.
// - After sleep the timebase continues from its held value without reload.
// - On an external clock the timebase keeps running during sleep; capture runs only in the synchronous mode, never in async.
`timescale 1ns/1ps
`default_nettype none
`include "cup_defines.svh"

module cup_capture_unit
  import cup_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_capture_input_pin,
  input wire logic i_ext_timebase_clk,
  input wire logic [1:0] i_timer_mode,
  input wire logic i_unit_enable,
  input wire logic [3:0] i_unit_mode_select,
  input wire logic i_sleep,
  input wire logic i_capture_irq_enable,
  input wire logic i_capture_irq_flag_clear,
  output logic [15:0] o_timebase_count_pair,
  output logic [15:0] o_capture_holding_pair,
  output logic o_capture_irq_flag,
  output logic o_capture_irq
);

  cup_top_state_t st_r;
  cup_top_state_t st_nxt;
  cup_pre_if pre_bus ();
  logic ext_edge;
  logic instr_tick;
  logic tmr_inc;
  logic mode_chg;
  logic cap_ok;

  // ----------------------------------------
  // Edge prescaler
  // ----------------------------------------
  assign cap_ok = i_timer_mode != `CUP_TMR_ASYNC;
  assign pre_bus.pin_lvl = st_r.pin_s2;
  assign pre_bus.mode = i_unit_mode_select;
  assign pre_bus.active = i_unit_enable && cup_is_capture(i_unit_mode_select) && cap_ok;

  cup_prescaler u_prescaler (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .bus (pre_bus)
  );

  // ----------------------------------------
  // Timebase, capture and flag
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_s1 = i_capture_input_pin;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.ext_s1 = i_ext_timebase_clk;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_prev = st_r.ext_s2;
    st_nxt.div = st_r.div + 2'h1;
    ext_edge = st_r.ext_s2 & ~st_r.ext_prev;
    instr_tick = st_r.div == `CUP_DIV_LAST;
    if (i_timer_mode == `CUP_TMR_TIMER) begin
      tmr_inc = instr_tick && !i_sleep;
    end else begin
      tmr_inc = ext_edge;
    end
    if (tmr_inc) begin
      st_nxt.tmr = st_r.tmr + `CUP_TMR_ONE;
    end
    st_nxt.mode_q = i_unit_mode_select;
    st_nxt.en_q = i_unit_enable;
    mode_chg = i_unit_enable && st_r.en_q && i_unit_mode_select != st_r.mode_q;
    if (i_capture_irq_flag_clear) begin
      st_nxt.flag = 1'b0;
    end
    if (pre_bus.evt) begin
      st_nxt.hold = st_r.tmr;
      st_nxt.flag = 1'b1;
    end
    if (mode_chg) begin
      st_nxt.flag = 1'b1;
    end
    st_nxt.irq = st_nxt.flag && i_capture_irq_enable;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_timebase_count_pair = st_r.tmr;
  assign o_capture_holding_pair = st_r.hold;
  assign o_capture_irq_flag = st_r.flag;
  assign o_capture_irq = st_r.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_capture_evt;
    pre_bus.evt;
  endsequence

  sequence s_captured;
    st_r.hold == $past(st_r.tmr) && st_r.flag;
  endsequence

  property p_capture_copies;
    @(posedge i_clock) disable iff (!i_rst_n) s_capture_evt |=> s_captured;
  endproperty
  a_capture_copies: assert property (p_capture_copies) else $error("capture not stored");

  property p_mode_change_flag;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_unit_enable && st_r.en_q && i_unit_mode_select != st_r.mode_q |=> st_r.flag;
  endproperty
  a_mode_change_flag: assert property (p_mode_change_flag) else $error("no flag on mode change");

  property p_sleep_freeze;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_sleep && i_timer_mode == `CUP_TMR_TIMER |=> st_r.tmr == $past(st_r.tmr);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) else $error("timer ran in sleep");

  sequence s_wake;
    i_sleep && i_timer_mode == `CUP_TMR_TIMER ##1 !i_sleep;
  endsequence

  property p_wake_resume;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_wake |-> st_r.tmr == $past(st_r.tmr) ##4 st_r.tmr == $past(st_r.tmr, 4) + `CUP_TMR_ONE;
  endproperty
  a_wake_resume: assert property (p_wake_resume) else $error("timer reloaded on wake");

  property p_instr_count;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_timer_mode == `CUP_TMR_TIMER && !i_sleep && st_r.div == `CUP_DIV_LAST
      |=> st_r.tmr == $past(st_r.tmr) + `CUP_TMR_ONE;
  endproperty
  a_instr_count: assert property (p_instr_count) else $error("instruction tick missed");

  property p_ext_in_sleep;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_timer_mode == `CUP_TMR_SYNC && i_sleep && st_r.ext_s2 && !st_r.ext_prev
      |=> st_r.tmr == $past(st_r.tmr) + `CUP_TMR_ONE;
  endproperty
  a_ext_in_sleep: assert property (p_ext_in_sleep) else $error("ext count stopped");

  property p_reset_outputs;
    @(posedge i_clock)
      !i_rst_n |=> st_r.tmr == '0 && st_r.hold == '0 && !st_r.flag && !st_r.irq;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared by reset");

  property p_flag_sticky;
    @(posedge i_clock) disable iff (!i_rst_n)
      st_r.flag && !i_capture_irq_flag_clear |=> st_r.flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

  property p_flag_clear;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_capture_irq_flag_clear && !pre_bus.evt && !mode_chg |=> !st_r.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");

  property p_irq_gate;
    @(posedge i_clock) disable iff (!i_rst_n)
      1'b1 |=> st_r.irq == (st_r.flag && $past(i_capture_irq_enable));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not flag and enable");

  sequence s_async_held;
    i_timer_mode == `CUP_TMR_ASYNC ##1 i_timer_mode == `CUP_TMR_ASYNC;
  endsequence

  property p_async_no_capture;
    @(posedge i_clock) disable iff (!i_rst_n) s_async_held |=> $stable(st_r.hold);
  endproperty
  a_async_no_capture: assert property (p_async_no_capture) else $error("capture in async mode");

  property p_idle_no_event;
    @(posedge i_clock) disable iff (!i_rst_n) !pre_bus.active |=> !pre_bus.evt;
  endproperty
  a_idle_no_event: assert property (p_idle_no_event) else $error("event while idle");

  property p_hold_stable;
    @(posedge i_clock) disable iff (!i_rst_n) !pre_bus.evt |=> $stable(st_r.hold);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("holding pair moved");

  property p_no_tick_between;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_timer_mode == `CUP_TMR_TIMER && st_r.div != `CUP_DIV_LAST |=> $stable(st_r.tmr);
  endproperty
  a_no_tick_between: assert property (p_no_tick_between) else $error("timer ran off tick");

  property p_ext_awake;
    @(posedge i_clock) disable iff (!i_rst_n)
      i_timer_mode == `CUP_TMR_SYNC && !i_sleep && st_r.ext_s2 && !st_r.ext_prev
      |=> st_r.tmr == $past(st_r.tmr) + `CUP_TMR_ONE;
  endproperty
  a_ext_awake: assert property (p_ext_awake) else $error("ext edge not counted");

endmodule

`default_nettype wire

/* dv/cup_src_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----
// Far-side pin and clock source
// ----
module cup_src_model (
  input wire logic i_clock,
  input wire logic i_fire,
  input wire logic i_ext_run,
  output logic o_pin,
  output logic o_ext_clk
);
  logic [2:0] ph = 3'h0;
  logic [1:0] ec = 2'h0;
  initial o_pin = 1'b0;
  initial o_ext_clk = 1'b0;
  // Pulse: three cycles high, then at least four low
  always @(posedge i_clock) begin
    if (ph != 3'h0) begin
      ph <= ph - 3'h1;
      o_pin <= (ph > 3'h4);
    end else if (i_fire) begin
      ph <= 3'h6;
      o_pin <= 1'b1;
    end
  end
  // Timebase clock, three cycles a level, still when idle
  always @(posedge i_clock) begin
    if (!i_ext_run) begin
      ec <= 2'h0;
      o_ext_clk <= 1'b0;
    end else if (ec == 2'h2) begin
      ec <= 2'h0;
      o_ext_clk <= ~o_ext_clk;
    end else begin
      ec <= ec + 2'h1;
    end
  end
endmodule

`default_nettype wire

/* dv/capture_unit_prescale_sleep_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module capture_unit_prescale_sleep_tb;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic fire = 1'b0;
  logic ext_run = 1'b0;
  logic pin, ext_clk, flag, irq;
  logic [1:0] tmode = 2'h0;
  logic en = 1'b1;
  logic sleep = 1'b0;
  logic ie = 1'b0;
  logic iep = 1'b0;
  logic fclr = 1'b0;
  logic [3:0] msel = 4'h0;
  logic [15:0] tcnt, hold, t0, hp, tp;
  logic [31:0] r;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 32'hb4f65735;
  int n;

  always #25 i_clock = ~i_clock;

  cup_src_model u_src (.i_clock(i_clock), .i_fire(fire), .i_ext_run(ext_run), .o_pin(pin), .o_ext_clk(ext_clk));
  cup_capture_unit u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_capture_input_pin(pin),
    .i_ext_timebase_clk(ext_clk), .i_timer_mode(tmode), .i_unit_enable(en), .i_unit_mode_select(msel),
    .i_sleep(sleep), .i_capture_irq_enable(ie), .i_capture_irq_flag_clear(fclr),
    .o_timebase_count_pair(tcnt), .o_capture_holding_pair(hold), .o_capture_irq_flag(flag), .o_capture_irq(irq));

  // ----
  // Checking helpers
  // ----
  task automatic close_out();
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic int need(input logic [3:0] m);
    return (m == 4'h6) ? 4 : (m == 4'h7) ? 16 : 1;
  endfunction

  task automatic tick(input int c);
    repeat (c) @(negedge i_clock);
  endtask

  task automatic pulse(input int c);
    repeat (c) begin
      fire = 1'b1;
      tick(1);
      fire = 1'b0;
      tick(8);
    end
  endtask

  task automatic clr();
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
    tick(1);
  endtask

  task automatic setm(input logic [3:0] m);
    msel = 4'h0;
    tick(2);
    msel = m;
    tick(2);
    chk1(flag, 1'b1);
    clr();
  endtask

  always @(posedge i_clock) begin
    iep <= ie;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end

  always @(negedge i_clock) begin
    if (i_rst_n && hold !== hp) chk16(hold, tp);
    if (i_rst_n) chk1(irq, flag & iep);
    hp = hold;
    tp = tcnt;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    tick(7);
    i_rst_n = 1'b1;
    chk16(tcnt, 16'h0000);
    for (int m = 4; m < 8; m++) begin
      setm(m[3:0]);
      for (int k = 0; k < need(m[3:0]); k++) begin
        chk1(flag, 1'b0);
        pulse(1);
      end
      chk1(flag, 1'b1);
    end
    setm(4'h6);
    pulse(2);
    setm(4'h6);
    pulse(3);
    chk1(flag, 1'b0);
    setm(4'h6);
    pulse(2);
    en = 1'b0;
    tick(2);
    en = 1'b1;
    pulse(3);
    chk1(flag, 1'b0);
    setm(4'h7);
    pulse(5);
    msel = 4'h6;
    tick(2);
    chk1(flag, 1'b1);
    clr();
    pulse(1);
    chk1(flag, 1'b1);
    setm(4'h6);
    pulse(2);
    i_rst_n = 1'b0;
    tick(2);
    chk1(flag, 1'b0);
    i_rst_n = 1'b1;
    tick(2);
    clr();
    pulse(3);
    chk1(flag, 1'b0);
    sleep = 1'b1;
    t0 = tcnt;
    tick(20);
    chk16(tcnt, t0);
    sleep = 1'b0;
    tick(40);
    chk16(tcnt, t0 + 16'h000A);
    tmode = 2'h1;
    ext_run = 1'b1;
    sleep = 1'b1;
    setm(4'h5);
    t0 = tcnt;
    pulse(1);
    chk1(flag, 1'b1);
    chk1(tcnt !== t0, 1'b1);
    sleep = 1'b0;
    tmode = 2'h2;
    setm(4'h5);
    pulse(1);
    chk1(flag, 1'b0);
    tmode = 2'h0;
    repeat (6) begin
      r = $random(seed);
      n = int'(r[2:1]) + 2;
      ie = 1'b0;
      setm(4'h6);
      ie = r[0];
      pulse(n);
      chk1(flag, n >= 4);
    end
    close_out();
  end
endmodule

`default_nettype wire
